// >>> sgc_pkg.sv
// constants shared by the global control, storm limit and led block
// =============================================================
// What this block does
// - low and high rate bits form one limit
// - period 50 ms at 100M, 500 ms at 10M
// - low rate byte resets to 0x4a
// - bit 3 set disables phy power save
// - mode 0 led codes per speed and duplex
// - mode 1 led codes per speed and duplex
// - leds are active low, one means off
// - rate bits 10:8 in previous register, reset zero
// - limit applies only when port enable set
package sgc_pkg;
    // =========================================================
    // register offsets
    localparam logic [7:0] ADDR_RATE_HIGH = 8'h06;
    localparam logic [7:0] ADDR_RATE_LOW = 8'h07;
    localparam logic [7:0] ADDR_TEST_A = 8'h08;
    localparam logic [7:0] ADDR_TEST_B = 8'h09;
    localparam logic [7:0] ADDR_TEST_C = 8'h0a;
    localparam logic [7:0] ADDR_PSAVE_LED = 8'h0b;
    localparam logic [3:0] PORT_CTRL_LOW_NIBBLE = 4'h0;
    localparam logic [3:0] PORT_FIRST_BLOCK = 4'h1;
    localparam logic [3:0] PORT_LAST_BLOCK = 4'h5;
    // =========================================================
    // field positions
    localparam int RATE_HIGH_MSB = 2;
    localparam int PSAVE_DIS_BIT = 3;
    localparam int FACTORY_BIT = 2;
    localparam int LED_MODE_BIT = 1;
    localparam int CFG_RSVD_BIT = 0;
    localparam int STORM_EN_BIT = 7;
    localparam int NUM_PORTS = 5;
    localparam int RATE_W = 11;
    // =========================================================
    // reset values
    localparam logic [7:0] RST_RATE_LOW = 8'h4a;
    localparam logic [2:0] RST_RATE_HIGH = 3'h0;
    localparam logic [7:0] RST_TEST_A = 8'h24;
    localparam logic [7:0] RST_TEST_B = 8'h28;
    localparam logic [7:0] RST_TEST_C = 8'h24;
    localparam logic [2:0] LED_ALL_OFF = 3'h7;
    // =========================================================
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int PERIOD_FAST_MS = 50;
    localparam int PERIOD_SLOW_MS = 500;
    localparam int PERIOD_FAST_CYCLES = CLK_HZ / 1000 * PERIOD_FAST_MS;
    localparam int SLOW_TICKS = PERIOD_SLOW_MS / PERIOD_FAST_MS;
endpackage

// >>> sgc_port.sv
// one switch port: storm block counter and link led encoder
`timescale 1ns/1ps
`default_nettype none
module sgc_port
    import sgc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [RATE_W-1:0] storm_limit,
    input wire logic storm_enable,
    input wire logic led_mode,
    input wire logic fast_tick,
    input wire logic slow_tick,
    input wire logic link_up,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic block_seen,
    output logic block_drop,
    output logic [2:0] led_n
);
    // =========================================================
    // storm counter
    logic [RATE_W-1:0] blk_count;
    wire period_end = speed_100 ? fast_tick : slow_tick;
    wire over_limit = blk_count >= storm_limit;
    wire accept = block_seen && storm_enable && !over_limit;
    wire reject = block_seen && storm_enable && over_limit && !period_end;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || period_end) begin
            blk_count <= '0;
        end else if (accept) begin
            blk_count <= blk_count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            block_drop <= 1'b0;
        end else begin
            block_drop <= reject;
        end
    end

    // =========================================================
    // led encoder, zero lights the indicator
    wire [2:0] code_mode0 = {1'b0, !full_duplex, !speed_100};
    wire [2:0] code_mode1 = {!speed_100, speed_100, !full_duplex};
    wire [2:0] next_led_n = !link_up ? LED_ALL_OFF : (led_mode ? code_mode1 : code_mode0);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            led_n <= LED_ALL_OFF;
        end else begin
            led_n <= next_led_n;
        end
    end

    // =========================================================
    // checks
    AST_MODE0_CODES: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && link_up && !led_mode) |=>
        led_n == {1'b0, !$past(full_duplex), !$past(speed_100)})
        else $error("mode 0 led code wrong");
    AST_MODE1_CODES: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && link_up && led_mode && speed_100) |=> led_n == {2'b01, !$past(full_duplex)})
        else $error("mode 1 led code wrong");
    AST_LINK_DOWN_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !link_up |=> led_n == 3'h7)
        else $error("leds not dark with link down");
    AST_NO_LIMIT_DISABLED: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !storm_enable |=> !block_drop)
        else $error("drop while storm protection disabled");
    AST_DROP_AT_LIMIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (block_seen && storm_enable && !period_end) |=>
        block_drop == ($past(blk_count) >= $past(storm_limit)))
        else $error("drop decision does not match limit");
    COV_DROP: cover property (@(posedge clk_sys) disable iff (sys_rst) block_drop);
    COV_MODE1_LIT: cover property (@(posedge clk_sys) disable iff (sys_rst)
        led_mode && link_up ##1 led_n == 3'h5);
endmodule // sgc_port
`default_nettype wire

// >>> sgc_top.sv
// global storm rate, factory test and power save / led mode registers
`timescale 1ns/1ps
`default_nettype none
module sgc_top
    import sgc_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_FAST_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic led_mode_strap_pin,
    input wire logic [NUM_PORTS-1:0] port_link_up,
    input wire logic [NUM_PORTS-1:0] port_speed_100,
    input wire logic [NUM_PORTS-1:0] port_full_duplex,
    input wire logic [NUM_PORTS-1:0] port_block_seen,
    output logic [NUM_PORTS-1:0] port_block_drop,
    output logic [3*NUM_PORTS-1:0] port_indicator_outputs,
    output logic phy_power_save_disable
);
    // =========================================================
    // registers
    logic [2:0] rate_high;
    logic [7:0] rate_low;
    logic [7:0] test_a;
    logic [7:0] test_b;
    logic [7:0] test_c;
    logic factory_bit;
    logic led_mode;
    logic cfg_rsvd;
    logic [NUM_PORTS-1:0] storm_en;
    logic strap_s1;
    logic strap_s2;

    // =========================================================
    // address decode
    wire sel_high = reg_addr == ADDR_RATE_HIGH;
    wire sel_low = reg_addr == ADDR_RATE_LOW;
    wire sel_ta = reg_addr == ADDR_TEST_A;
    wire sel_tb = reg_addr == ADDR_TEST_B;
    wire sel_tc = reg_addr == ADDR_TEST_C;
    wire sel_cfg = reg_addr == ADDR_PSAVE_LED;
    wire port_blk_ok = reg_addr[3:0] == PORT_CTRL_LOW_NIBBLE &&
        reg_addr[7:4] >= PORT_FIRST_BLOCK && reg_addr[7:4] <= PORT_LAST_BLOCK;
    wire [3:0] port_blk = reg_addr[7:4] - PORT_FIRST_BLOCK;
    wire [NUM_PORTS-1:0] sel_port;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_sel
            assign sel_port[gi] = port_blk_ok && port_blk == 4'(gi);
        end
    endgenerate

    wire [RATE_W-1:0] storm_limit = {rate_high, rate_low};
    wire [7:0] cfg_word = {4'h0, phy_power_save_disable, factory_bit, led_mode, cfg_rsvd};
    wire [7:0] port_word = port_blk_ok ? {storm_en[port_blk[2:0]], 7'h00} : 8'h00;
    wire [7:0] next_rdata = sel_high ? {5'h00, rate_high} :
        sel_low ? rate_low :
        sel_ta ? test_a :
        sel_tb ? test_b :
        sel_tc ? test_c :
        sel_cfg ? cfg_word : port_word;

    // =========================================================
    // strap synchroniser, free running
    always_ff @(posedge clk_sys) begin
        strap_s1 <= led_mode_strap_pin;
        strap_s2 <= strap_s1;
    end

    // =========================================================
    // register writes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rate_high <= RST_RATE_HIGH;
            rate_low <= RST_RATE_LOW;
        end else if (reg_wr && sel_high) begin
            rate_high <= reg_wdata[RATE_HIGH_MSB:0];
        end else if (reg_wr && sel_low) begin
            rate_low <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            test_a <= RST_TEST_A;
            test_b <= RST_TEST_B;
            test_c <= RST_TEST_C;
        end else if (reg_wr) begin
            if (sel_ta) test_a <= reg_wdata;
            if (sel_tb) test_b <= reg_wdata;
            if (sel_tc) test_c <= reg_wdata;
        end
    end

    // led mode follows the strap level while reset is held
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phy_power_save_disable <= 1'b0;
            factory_bit <= 1'b0;
            led_mode <= strap_s2;
            cfg_rsvd <= 1'b0;
        end else if (reg_wr && sel_cfg) begin
            phy_power_save_disable <= reg_wdata[PSAVE_DIS_BIT];
            factory_bit <= reg_wdata[FACTORY_BIT];
            led_mode <= reg_wdata[LED_MODE_BIT];
            cfg_rsvd <= reg_wdata[CFG_RSVD_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            storm_en <= '0;
        end else if (reg_wr) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (sel_port[i]) storm_en[i] <= reg_wdata[STORM_EN_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // =========================================================
    // period divider: fast tick every 50 ms, slow every tenth
    logic [31:0] tick_cnt;
    logic [3:0] slow_cnt;
    logic fast_tick;
    logic slow_tick;
    wire tick_wrap = tick_cnt == 32'(PERIOD_CYCLES - 1);
    wire slow_wrap = slow_cnt == 4'(SLOW_TICKS - 1);

    always_ff @(posedge clk_sys) begin
        if (sys_rst || tick_wrap) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            slow_cnt <= 4'h0;
        end else if (tick_wrap) begin
            slow_cnt <= slow_wrap ? 4'h0 : slow_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fast_tick <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            fast_tick <= tick_wrap;
            slow_tick <= tick_wrap && slow_wrap;
        end
    end

    // =========================================================
    // ports
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            sgc_port u_port (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .storm_limit(storm_limit),
                .storm_enable(storm_en[gi]),
                .led_mode(led_mode),
                .fast_tick(fast_tick),
                .slow_tick(slow_tick),
                .link_up(port_link_up[gi]),
                .speed_100(port_speed_100[gi]),
                .full_duplex(port_full_duplex[gi]),
                .block_seen(port_block_seen[gi]),
                .block_drop(port_block_drop[gi]),
                .led_n(port_indicator_outputs[3*gi+2:3*gi])
            );
        end
    endgenerate

    // =========================================================
    // checks
    logic [3:0] fast_gap;
    // 4'hf marks no tick since reset, so the first tick is not timed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fast_gap <= 4'hf;
        end else if (fast_tick) begin
            fast_gap <= 4'h0;
        end else if (fast_gap != 4'hf) begin
            fast_gap <= fast_gap + 4'h1;
        end
    end

    // fast ticks counted since the last slow tick
    logic [3:0] fast_since_slow;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || slow_tick) begin
            fast_since_slow <= 4'h0;
        end else if (fast_tick) begin
            fast_since_slow <= fast_since_slow + 4'h1;
        end
    end

    AST_RATE_LOW_RESET: assert property (@(posedge clk_sys)
        sys_rst |=> rate_low == 8'h4a)
        else $error("rate low byte reset value wrong");
    AST_RATE_HIGH_RESET: assert property (@(posedge clk_sys)
        sys_rst |=> rate_high == 3'h0)
        else $error("rate high bits reset value wrong");
    AST_LIMIT_JOIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && sel_high |=> reg_rdata == {5'h00, storm_limit[10:8]})
        else $error("rate high readback mismatch");
    AST_PSAVE_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_cfg |=> phy_power_save_disable == $past(reg_wdata[3]))
        else $error("power save disable bit not written");
    AST_STRAP_CAPTURE: assert property (@(posedge clk_sys)
        $past(sys_rst) && !sys_rst |-> led_mode == $past(strap_s2))
        else $error("led mode not taken from strap");
    AST_SLOW_WITH_FAST: assert property (@(posedge clk_sys) disable iff (sys_rst)
        slow_tick |-> fast_tick)
        else $error("slow tick without fast tick");
    AST_FAST_SPACING: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fast_tick && !$past(sys_rst) && fast_gap != 4'hf && PERIOD_CYCLES < 15 |->
        fast_gap == 4'(PERIOD_CYCLES - 1))
        else $error("fast tick spacing wrong");
    AST_UNMAPPED_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && !(sel_high || sel_low || sel_ta || sel_tb || sel_tc || sel_cfg || port_blk_ok)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // =========================================================
    // tick spacing
    AST_SLOW_SPACING: assert property (@(posedge clk_sys) disable iff (sys_rst)
        slow_tick |-> fast_since_slow == 4'(SLOW_TICKS - 1))
        else $error("slow tick not every tenth fast tick");
    AST_TICK_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fast_tick && PERIOD_CYCLES > 1 |=> !fast_tick)
        else $error("fast tick longer than one cycle");

    // =========================================================
    // register writes, reads and reset values
    AST_RATE_LOW_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_low |=> storm_limit[7:0] == $past(reg_wdata))
        else $error("rate low byte not written");
    AST_RATE_HIGH_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_high |=> storm_limit[10:8] == $past(reg_wdata[RATE_HIGH_MSB:0]))
        else $error("rate high bits not written");
    AST_RATE_LOW_READ: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && sel_low |=> reg_rdata == $past(rate_low))
        else $error("rate low readback mismatch");
    AST_TEST_RESET: assert property (@(posedge clk_sys)
        sys_rst |=> test_a == RST_TEST_A && test_b == RST_TEST_B && test_c == RST_TEST_C)
        else $error("factory test reset value wrong");
    AST_TEST_A_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_ta |=> test_a == $past(reg_wdata))
        else $error("first factory test byte not written");
    AST_TEST_B_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_tb |=> test_b == $past(reg_wdata))
        else $error("second factory test byte not written");
    AST_TEST_C_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_tc |=> test_c == $past(reg_wdata))
        else $error("third factory test byte not written");
    AST_PSAVE_RESET: assert property (@(posedge clk_sys)
        sys_rst |=> !phy_power_save_disable && !factory_bit && !cfg_rsvd)
        else $error("config bits reset value wrong");
    AST_CFG_READ: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && sel_cfg |=> reg_rdata[7:4] == 4'h0 &&
        reg_rdata[PSAVE_DIS_BIT] == $past(phy_power_save_disable) &&
        reg_rdata[LED_MODE_BIT] == $past(led_mode))
        else $error("config readback mismatch");
    AST_LED_MODE_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_cfg |=> led_mode == $past(reg_wdata[LED_MODE_BIT]))
        else $error("led mode bit not written");
    AST_LED_MODE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(reg_wr && sel_cfg) |=> $stable(led_mode))
        else $error("led mode changed without a write");
    AST_STORM_EN_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && port_blk_ok |=> (storm_en & $past(sel_port)) ==
        ($past(reg_wdata[STORM_EN_BIT]) ? $past(sel_port) : 5'h00))
        else $error("storm enable bit not written");
    AST_PORT_WORD_READ: assert property (@(posedge clk_sys) disable iff (sys_rst)
        reg_rd && port_blk_ok |=> reg_rdata[6:0] == 7'h00)
        else $error("port control spare bits not zero");
    AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_OUTPUTS_RESET: assert property (@(posedge clk_sys)
        sys_rst |=> port_indicator_outputs == 15'h7fff && port_block_drop == 5'h00)
        else $error("port outputs not idle after reset");

    // =========================================================
    // coverage
    COV_SLOW_TICK: cover property (@(posedge clk_sys) disable iff (sys_rst) slow_tick);
    COV_CFG_WRITE_READ: cover property (@(posedge clk_sys) disable iff (sys_rst)
        reg_wr && sel_cfg ##1 reg_rd && sel_cfg);
endmodule // sgc_top
`default_nettype wire

// >>> sgc_top_tb.sv
// self-checking bench for the global rate, factory test and led mode registers
`timescale 1ns/1ps
`default_nettype none
module sgc_top_tb
    import sgc_pkg::*;
;
    // =========================================================
    // stimulus and observation
    localparam int PER = 10;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic led_mode_strap_pin = 1'b0;
    logic [NUM_PORTS-1:0] port_link_up = 5'h0f;
    logic [NUM_PORTS-1:0] port_speed_100 = 5'h05;
    logic [NUM_PORTS-1:0] port_full_duplex = 5'h03;
    logic [NUM_PORTS-1:0] port_block_seen = 5'h00;
    logic [NUM_PORTS-1:0] port_block_drop;
    logic [3*NUM_PORTS-1:0] port_indicator_outputs;
    logic phy_power_save_disable;
    logic [7:0] got;
    int miscompares = 0;
    int n_checks = 0;
    int drops [3];
    // reset table rows: address and value expected after reset with strap low
    logic [7:0] row_addr [8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h10, 8'h0c};
    logic [7:0] row_val [8] = '{8'h00, 8'h4a, 8'h24, 8'h28, 8'h24, 8'h00, 8'h00, 8'h00};

    always #10 clk_sys = ~clk_sys;

    sgc_top #(.PERIOD_CYCLES(PER)) i_dut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .led_mode_strap_pin(led_mode_strap_pin),
        .port_link_up(port_link_up),
        .port_speed_100(port_speed_100),
        .port_full_duplex(port_full_duplex),
        .port_block_seen(port_block_seen),
        .port_block_drop(port_block_drop),
        .port_indicator_outputs(port_indicator_outputs),
        .phy_power_save_disable(phy_power_save_disable)
    );

    // =========================================================
    // shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    function automatic logic [2:0] led_exp(logic m, logic up, logic s, logic fd);
        if (!up) return LED_ALL_OFF;
        return m ? {~s, s, ~fd} : {1'b0, ~fd, ~s};
    endfunction

    task automatic chk_leds(input logic m);
        logic [3*NUM_PORTS-1:0] e;
        repeat (2) @(posedge clk_sys);
        #1;
        for (int p = 0; p < NUM_PORTS; p++)
            e[3*p +: 3] = led_exp(m, port_link_up[p], port_speed_100[p], port_full_duplex[p]);
        chk("port leds", 16'(e), 16'(port_indicator_outputs));
        $display("led test mode %0d done", m);
    endtask

    // every port pulses a block each cycle; drops of ports 0..2 are counted over span
    task automatic stream(input int skip, input int span);
        drops = '{0, 0, 0};
        for (int c = 0; c <= skip + span; c++) begin
            @(posedge clk_sys);
            port_block_seen <= (c < skip + span) ? 5'h1f : 5'h00;
            #1;
            if (c > skip)
                for (int p = 0; p < 3; p++) drops[p] += int'(port_block_drop[p]);
        end
    endtask

    // called at time zero or right at a rising edge; reset is held for six edges
    task automatic do_reset(input logic strap);
        sys_rst <= 1'b1;
        led_mode_strap_pin <= strap;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("leds in reset", 16'h7fff, 16'(port_indicator_outputs));
        chk("power save in reset", 16'h0, 16'(phy_power_save_disable));
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // =========================================================
    // main sequence
    initial begin
        do_reset(1'b0);
        for (int i = 0; i < 8; i++) begin
            rd(row_addr[i], got);
            chk("reset value", 16'(row_val[i]), 16'(got));
        end
        rd(ADDR_RATE_LOW, got);
        chk("rate low reread", 16'h4a, 16'(got));
        @(posedge clk_sys);
        #1;
        chk("idle read data", 16'h0, 16'(reg_rdata));
        $display("reset table test done");
        chk_leds(1'b0);
        wr(ADDR_PSAVE_LED, 8'h08);
        #1;
        chk("power save disable", 16'h1, 16'(phy_power_save_disable));
        rd(ADDR_PSAVE_LED, got);
        chk("psave led readback", 16'h08, 16'(got));
        wr(ADDR_PSAVE_LED, 8'hf7);
        #1;
        chk("power save enable", 16'h0, 16'(phy_power_save_disable));
        rd(ADDR_PSAVE_LED, got);
        chk("psave led readback", 16'h07, 16'(got));
        chk_leds(1'b1);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_TEST_A + 8'(i), 8'ha5 ^ 8'(i));
            rd(ADDR_TEST_A + 8'(i), got);
            chk("factory readback", 16'(8'ha5 ^ 8'(i)), 16'(got));
        end
        wr(8'h0c, 8'h55);
        rd(8'h0c, got);
        chk("unmapped read", 16'h0, 16'(got));
        wr(ADDR_RATE_HIGH, 8'hff);
        rd(ADDR_RATE_HIGH, got);
        chk("rate high bits", 16'h07, 16'(got));
        wr(8'h50, 8'hff);
        rd(8'h50, got);
        chk("port 5 storm enable", 16'h80, 16'(got));
        $display("register test done");
        wr(ADDR_RATE_HIGH, 8'h00);
        wr(ADDR_RATE_LOW, 8'h02);
        wr(8'h10, 8'h80);
        wr(8'h20, 8'h80);
        stream(10 * PER, 10 * PER);
        chk("drops 100M port", 16'(7 * 10), 16'(drops[0]));
        chk("drops 10M port", 16'(10 * PER - 3), 16'(drops[1]));
        chk("drops disabled port", 16'h0, 16'(drops[2]));
        wr(ADDR_RATE_HIGH, 8'h01);
        stream(10 * PER, 10 * PER);
        chk("drops high limit", 16'h0, 16'(drops[0] + drops[1]));
        $display("storm test done");
        @(posedge clk_sys);
        do_reset(1'b1);
        rd(ADDR_PSAVE_LED, got);
        chk("strap led mode", 16'h02, 16'(got));
        rd(ADDR_RATE_LOW, got);
        chk("rate low after reset", 16'h4a, 16'(got));
        rd(ADDR_RATE_HIGH, got);
        chk("rate high after reset", 16'h00, 16'(got));
        chk_leds(1'b1);
        $display("strap test done");
        conclude();
    end
endmodule // sgc_top_tb
`default_nettype wire
